// File: rtl/cwdio_defs.svh
`ifndef CWDIO_DEFS_SVH
`define CWDIO_DEFS_SVH

// Register indices; byte address on the bus is four times the index
`define CW_DATA_IDX 8'h18
`define CW_CMD_IDX 8'h1A
`define CW_DIO_IDX 8'h1C
`define CW_DRV_IDX 8'h20

// Number of counter-chip registers behind the data window
`define CW_NREGS 18

// Command code fields
`define CW_CODE_HI_MSB 7
`define CW_CODE_HI_LSB 5
`define CW_CODE_GRP_MSB 4
`define CW_CODE_GRP_LSB 3
`define CW_CODE_ELEM_MSB 2
`define CW_CODE_ELEM_LSB 0
`define CW_ELEM_SPECIAL 3'h7
`define CW_GRP_MODE 2'h0
`define CW_GRP_LOAD 2'h1
`define CW_GRP_HOLD 2'h2

// Pointer indices of the special registers
`define CW_PTR_MASTER 5'h0F
`define CW_PTR_CMP1 5'h10
`define CW_PTR_CMP2 5'h11

// Status and line field positions
`define CW_STAT_BOF_BIT 0
`define CW_STAT_OUT_LSB 1
`define CW_DIO_A_LSB 0
`define CW_DIO_B_LSB 4
`define CW_DRV_A_BIT 0
`define CW_DRV_B_BIT 1

// Reset values
`define CW_PTR_RST 5'h00
`define CW_PATTERN_RST 8'h00
`define CW_DRV_RST 2'h0
`define CW_CODE_RST 8'h00

`endif

// File: rtl/cwdio_pkg.sv
`default_nettype none
package cwdio_pkg;

  // Command handed to the counter chip
  typedef struct packed {
    logic strobe;      // One-cycle pulse per command write
    logic [7:0] code;  // Last command code written
  } cmd_out_type;

  // Drive of the eight digital lines
  typedef struct packed {
    logic [7:0] level; // Pattern levels, port B high nibble
    logic [7:0] oe;    // High while the board drives the line
  } dio_drive_type;

  // Read phase of the bus slave
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_FETCH = 2'b01,
    RD_DONE = 2'b10
  } rd_state_type;

endpackage : cwdio_pkg
`default_nettype wire

// File: rtl/cw_sync.sv
`default_nettype none
module cw_sync #(
  parameter int WIDTH = 1
) (
  // Clock and control
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage, read only by the second
  logic [WIDTH-1:0] meta_r;

  // Two-stage synchroniser, cleared by reset
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : cw_sync
`default_nettype wire

// File: rtl/cw_regmem.sv
`default_nettype none
module cw_regmem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 18,
  parameter int AW = 5
) (
  // Clock and enable
  input wire logic ref_clk,
  input wire logic ce,
  // Write side
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  // Registered read of the same address
  output logic [WIDTH-1:0] rdata
);

  // Storage; contents are undefined until software loads them
  logic [WIDTH-1:0] mem [DEPTH];

  // Registered read returns the word held before a same-cycle write, one port
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end

endmodule : cw_regmem
`default_nettype wire

// File: rtl/counter_window_and_dio_regs.sv
`include "cwdio_defs.svh"
`default_nettype none

// Function
// - Window reaches register picked by last valid command
// - Window at 0x18 writes/reads sixteen bits
// - Eighteen counter-chip registers behind the window
// - Command low byte goes to counter chip
// - 0x1A reads status, writes command
// - Status bits five-one show counter outputs
// - Status bit zero byte flag, rest undefined
// - 0x1C reads port B high, port A low
// - 0x1C write stores eight-bit output pattern
// - Port B driven only when its enable set
// - Port A driven only when its enable set
module counter_window_and_dio_regs
  import cwdio_pkg::*;
#(
  parameter int NREGS = `CW_NREGS
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Counter chip side
  input wire logic [4:0] ctr_out_pins,
  input wire logic byte_order_flag,
  output cmd_out_type ctr_cmd,
  // Digital lines
  input wire logic [7:0] dio_lines_in,
  output dio_drive_type dio_drive
);

  localparam int AW = 5;

  // Synchronised pin levels
  logic [4:0] ctr_out_s;  // Counter outputs
  logic bof_s;            // Byte order flag
  logic [7:0] dio_s;      // Digital line levels

  // Control and data state
  rd_state_type rd_state_r;  // Read phase
  rd_state_type rd_state_nxt;
  logic [AW-1:0] ptr_r;      // Selected counter register
  logic [7:0] pattern_r;     // Stored output pattern
  logic [1:0] drv_en_r;      // Port drive enables, bit1 = B
  logic [31:0] readdata_r;   // Registered read answer
  logic [7:0] code_r;        // Last command code
  logic strobe_r;            // Command pulse
  logic [15:0] mem_rdata;    // Registered counter register

  // Counter outputs and flag come from another chip
  cw_sync #(.WIDTH(6)) u_ctr_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ce(ce),
    .async_in({ctr_out_pins, byte_order_flag}),
    .sync_out({ctr_out_s, bof_s})
  );

  // Line readback sees the pins whoever drives them
  cw_sync #(.WIDTH(8)) u_dio_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ce(ce),
    .async_in(dio_lines_in),
    .sync_out(dio_s)
  );

  // Address decode; only lanes that carry the field take effect
  wire hit_data = avs_address == 8'({`CW_DATA_IDX, 2'b00});
  wire hit_cmd = avs_address == 8'({`CW_CMD_IDX, 2'b00});
  wire hit_dio = avs_address == 8'({`CW_DIO_IDX, 2'b00});
  wire hit_drv = avs_address == 8'({`CW_DRV_IDX, 2'b00});
  wire lanes16 = &avs_byteenable[1:0];
  wire wr_ok = ce && avs_write;
  wire wr_data = wr_ok && hit_data && lanes16;
  wire wr_cmd = wr_ok && hit_cmd && avs_byteenable[0];
  wire wr_dio = wr_ok && hit_dio && avs_byteenable[0];
  wire wr_drv = wr_ok && hit_drv && avs_byteenable[0];

  // Command code fields; upper bits of the word are not checked
  wire [7:0] cmd_code = avs_writedata[7:0];
  wire [2:0] code_hi =
    cmd_code[`CW_CODE_HI_MSB:`CW_CODE_HI_LSB];
  wire [1:0] code_grp =
    cmd_code[`CW_CODE_GRP_MSB:`CW_CODE_GRP_LSB];
  wire [2:0] code_elem =
    cmd_code[`CW_CODE_ELEM_MSB:`CW_CODE_ELEM_LSB];
  wire elem_ctr = code_elem >= 3'h1 && code_elem <= 3'h5;
  wire elem_spec = code_elem == `CW_ELEM_SPECIAL;

  // Pointer decode: mode, load, hold per counter, master, compares
  logic ptr_valid;
  logic [AW-1:0] ptr_dec;
  always_comb begin
    ptr_valid = 1'b0;
    ptr_dec = `CW_PTR_RST;
    if (code_hi == 3'h0 && elem_ctr && code_grp != 2'h3) begin
      ptr_valid = 1'b1;
      ptr_dec = AW'(code_grp * 5 + code_elem - 1);
    end else if (code_hi == 3'h0 && elem_spec) begin
      case (code_grp)
        `CW_GRP_MODE: begin
          ptr_valid = 1'b1;
          ptr_dec = `CW_PTR_CMP1;
        end
        `CW_GRP_LOAD: begin
          ptr_valid = 1'b1;
          ptr_dec = `CW_PTR_CMP2;
        end
        `CW_GRP_HOLD: begin
          ptr_valid = 1'b1;
          ptr_dec = `CW_PTR_MASTER;
        end
        default: begin
          ptr_valid = 1'b0;
        end
      endcase
    end
  end

  // Counter-chip registers, always addressed by the pointer
  cw_regmem #(.WIDTH(16), .DEPTH(NREGS), .AW(AW)) u_regs (
    .ref_clk(ref_clk),
    .ce(ce),
    .we(wr_data),
    .addr(ptr_r),
    .wdata(avs_writedata[15:0]),
    .rdata(mem_rdata)
  );

  // Read words; undefined status and readback bits read as zero
  wire [15:0] stat_word = {10'h000, ctr_out_s, bof_s};
  wire [15:0] dio_word = {8'h00, dio_s};
  wire [15:0] drv_word = {14'h0000, drv_en_r};
  wire [15:0] rd_mux =
    hit_data ? mem_rdata :
    hit_cmd ? stat_word :
    hit_dio ? dio_word :
    hit_drv ? drv_word : 16'h0000;

  // Read phases: fetch lets the memory follow the pointer
  always_comb begin
    case (rd_state_r)
      RD_IDLE: begin
        rd_state_nxt = avs_read ? RD_FETCH : RD_IDLE;
      end
      RD_FETCH: begin
        rd_state_nxt = RD_DONE;
      end
      RD_DONE: begin
        rd_state_nxt = RD_IDLE;
      end
      default: begin
        rd_state_nxt = RD_IDLE;
      end
    endcase
  end

  // Stall while frozen or while a read is being fetched
  assign avs_waitrequest = !ce || (avs_read && rd_state_r != RD_DONE);
  assign avs_readdata = readdata_r;

  // Read state and answer
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_state_r <= RD_IDLE;
      readdata_r <= 32'h00000000;
    end else if (ce) begin
      rd_state_r <= rd_state_nxt;
      if (rd_state_r == RD_FETCH) begin
        readdata_r <= {16'h0000, rd_mux};
      end
    end
  end

  // Pointer and command to the counter chip
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ptr_r <= `CW_PTR_RST;
      code_r <= `CW_CODE_RST;
      strobe_r <= 1'b0;
    end else if (ce) begin
      strobe_r <= wr_cmd;
      if (wr_cmd) begin
        code_r <= cmd_code;
      end
      if (wr_cmd && ptr_valid) begin
        ptr_r <= ptr_dec;
      end
    end
  end

  // Output pattern and drive enables; pattern upper byte dropped
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pattern_r <= `CW_PATTERN_RST;
      drv_en_r <= `CW_DRV_RST;
    end else if (ce) begin
      if (wr_dio) begin
        pattern_r <= avs_writedata[7:0];
      end
      if (wr_drv) begin
        drv_en_r <= avs_writedata[1:0];
      end
    end
  end

  // Line drive; a disabled port floats so outside sources win
  wire a_en = drv_en_r[`CW_DRV_A_BIT];
  wire b_en = drv_en_r[`CW_DRV_B_BIT];
  assign dio_drive.level = pattern_r;
  assign dio_drive.oe = {{4{b_en}}, {4{a_en}}};
  assign ctr_cmd.strobe = strobe_r;
  assign ctr_cmd.code = code_r;

  // Checks on the logic above
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence rd_start_s;
    ce && avs_read && rd_state_r == RD_IDLE;
  endsequence
  sequence rd_held_s;
    rd_start_s ##1 (ce && avs_read) [*2];
  endsequence

  ptr_follow_a: assert property (
    wr_cmd && ptr_valid |=> ptr_r == $past(ptr_dec))
    else $error("pointer did not follow command");
  ptr_range_a: assert property (
    ptr_r < AW'(NREGS))
    else $error("pointer outside register set");
  rd_timing_a: assert property (
    rd_held_s |-> $past(avs_waitrequest, 2) && $past(avs_waitrequest)
      && !avs_waitrequest)
    else $error("read timing broken");
  rd_wait_a: assert property (
    rd_start_s ##1 avs_read |-> rd_state_r == RD_FETCH && avs_waitrequest)
    else $error("read fetch step missing");
  cmd_pass_a: assert property (
    wr_cmd |=> ctr_cmd.strobe && ctr_cmd.code == $past(cmd_code))
    else $error("command code not passed");
  stat_read_a: assert property (
    rd_state_r == RD_FETCH && hit_cmd && ce
      |=> avs_readdata[5:0] == $past({ctr_out_s, bof_s}))
    else $error("status read wrong");
  stat_high_a: assert property (
    rd_state_r == RD_DONE && hit_cmd |-> avs_readdata[31:6] == '0)
    else $error("status upper bits not zero");
  dio_read_a: assert property (
    rd_state_r == RD_FETCH && hit_dio && ce
      |=> avs_readdata[15:0] == {8'h00, $past(dio_s)})
    else $error("line readback wrong");
  pat_store_a: assert property (
    wr_dio |=> dio_drive.level == $past(avs_writedata[7:0]))
    else $error("pattern not stored");
  b_drive_a: assert property (
    !drv_en_r[`CW_DRV_B_BIT] |-> dio_drive.oe[7:4] == 4'h0)
    else $error("port B driven while disabled");
  a_drive_a: assert property (
    $rose(drv_en_r[`CW_DRV_A_BIT]) |-> dio_drive.oe[3:0] == 4'hF)
    else $error("port A not driven when enabled");

  // Command pulse lasts one cycle; rejected codes keep the pointer
  strobe_pulse_a: assert property (
    ce && !wr_cmd |=> !ctr_cmd.strobe)
    else $error("command strobe longer than one cycle");
  ptr_hold_a: assert property (
    wr_cmd && !ptr_valid |=> $stable(ptr_r))
    else $error("pointer moved on unknown code");
  pat_hold_a: assert property (
    !wr_dio |=> $stable(pattern_r))
    else $error("pattern changed without write");

  // A disabled nibble floats, an enabled one drives all four lines
  a_off_a: assert property (
    !drv_en_r[`CW_DRV_A_BIT] |-> dio_drive.oe[3:0] == 4'h0)
    else $error("port A driven while disabled");
  b_on_a: assert property (
    drv_en_r[`CW_DRV_B_BIT] |-> dio_drive.oe[7:4] == 4'hF)
    else $error("port B not driven when enabled");

  // Readback trails the pins by exactly the two synchroniser stages
  lines_sync_a: assert property (
    ce [*2] |=> dio_s == $past(dio_lines_in, 2))
    else $error("line readback does not follow pins");

endmodule : counter_window_and_dio_regs
`default_nettype wire

// File: sim/cwdio_far_model.sv
`default_nettype none
module cwdio_far_model
  import cwdio_pkg::*;
(
  // Board side
  input wire dio_drive_type drive,
  // Outside sources
  input wire logic [7:0] ext_level,
  input wire logic [4:0] ctr_level,
  input wire logic ptr_flag,
  // Pins as the board sees them
  output logic [7:0] dio_lines_in,
  output logic [4:0] ctr_out_pins,
  output logic byte_order_flag
);
  timeunit 1ns;
  timeprecision 1ns;

  // Board wins a line only while it drives; otherwise outside source shows
  assign dio_lines_in = (drive.oe & drive.level)
                      | (~drive.oe & ext_level);
  // Counter outputs and byte flag come straight from the chip pins
  assign ctr_out_pins = ctr_level;
  assign byte_order_flag = ptr_flag;
endmodule : cwdio_far_model
`default_nettype wire

// File: sim/counter_window_and_dio_regs_tb.sv
`default_nettype none
module counter_window_and_dio_regs_tb;
  import cwdio_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // Clock, reset, bus
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // Far side
  cmd_out_type ctr_cmd;
  dio_drive_type dio_drive;
  logic [7:0] dio_lines_in;
  logic [7:0] ext_level = 8'hC3;
  logic [4:0] ctr_out_pins;
  logic [4:0] ctr_level = 5'h00;
  logic byte_order_flag;
  logic ptr_flag = 1'b0;
  // Bookkeeping
  int err_total = 0;
  int tests_run = 0;
  int i;
  logic [31:0] rd;
  logic [7:0] oe_exp;
  logic [7:0] code_tab [0:17];

  always #20 ref_clk = ~ref_clk;

  counter_window_and_dio_regs uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ctr_out_pins(ctr_out_pins),
    .byte_order_flag(byte_order_flag), .ctr_cmd(ctr_cmd),
    .dio_lines_in(dio_lines_in), .dio_drive(dio_drive)
  );

  cwdio_far_model far (
    .drive(dio_drive), .ext_level(ext_level), .ctr_level(ctr_level),
    .ptr_flag(ptr_flag), .dio_lines_in(dio_lines_in),
    .ctr_out_pins(ctr_out_pins), .byte_order_flag(byte_order_flag)
  );

  // Single exit point of the run
  task final_report;
    $display("Checks run %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  task chk(input string what, input logic [31:0] exp,
           input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Samples waitrequest at each rising edge, before that edge's updates
  // land; returns at the accepting edge
  task wait_ready;
    int n;
    n = 0;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 50) begin
        err_total++;
        $display("[FAIL] waitrequest expected 0 seen 1");
        final_report();
      end
      @(posedge ref_clk);
    end
  endtask : wait_ready

  task bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= 1'b1;
    wait_ready();
    avs_write <= 1'b0;
  endtask : bus_wr

  task bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    wait_ready();
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd

  // Status low six bits only; upper bits carry no meaning
  task chk_status(input logic [4:0] outs, input logic flag);
    @(posedge ref_clk);
    ctr_level <= outs;
    ptr_flag <= flag;
    repeat (4) @(posedge ref_clk);
    bus_rd(8'h68, rd);
    chk("status", {26'h0, outs, flag}, rd & 32'h3F);
  endtask : chk_status

  initial begin
    // Command codes of all eighteen window registers
    for (i = 0; i < 15; i++) begin
      code_tab[i] = 8'((i / 5) * 8 + (i % 5) + 1);
    end
    code_tab[15] = 8'h17;
    code_tab[16] = 8'h07;
    code_tab[17] = 8'h0F;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    chk("oe after reset", 32'h0, {24'h0, dio_drive.oe});
    // Sixteen-bit mode, then point at counter one mode
    bus_wr(8'h68, 16'hFFEF);
    bus_wr(8'h68, 16'hFF01);
    @(negedge ref_clk);
    chk("cmd strobe", 32'h1, {31'h0, ctr_cmd.strobe});
    chk("cmd code", 32'h01, {24'h0, ctr_cmd.code});
    @(negedge ref_clk);
    chk("cmd strobe end", 32'h0, {31'h0, ctr_cmd.strobe});
    // Fill every register, then read back in reverse order
    for (i = 0; i < 18; i++) begin
      bus_wr(8'h68, {8'hFF, code_tab[i]});
      bus_wr(8'h60, 16'(16'hA500 + i));
    end
    for (i = 17; i >= 0; i--) begin
      bus_wr(8'h68, {8'hFF, code_tab[i]});
      bus_rd(8'h60, rd);
      chk("window", {16'h0, 16'(16'hA500 + i)}, rd);
    end
    // A code outside the set must not move the pointer
    bus_wr(8'h68, 16'hFF1F);
    bus_rd(8'h60, rd);
    chk("window kept", 32'h0000_A500, rd);
    chk_status(5'h16, 1'b1);
    chk_status(5'h09, 1'b0);
    // Undriven lines show the outside levels
    bus_rd(8'h70, rd);
    chk("lines idle", 32'hC3, rd & 32'hFF);
    bus_wr(8'h70, 16'h005A);
    @(negedge ref_clk);
    chk("pattern", 32'h5A, {24'h0, dio_drive.level});
    chk("oe off", 32'h0, {24'h0, dio_drive.oe});
    // Enable combinations one to three; readback mixes board and outside
    for (i = 1; i < 4; i++) begin
      bus_wr(8'h80, 16'(i));
      oe_exp = {{4{i[1]}}, {4{i[0]}}};
      @(negedge ref_clk);
      chk("oe", {24'h0, oe_exp}, {24'h0, dio_drive.oe});
      repeat (3) @(posedge ref_clk);
      bus_rd(8'h70, rd);
      chk("lines", {24'h0, (oe_exp & 8'h5A) | (~oe_exp & 8'hC3)},
          rd & 32'hFF);
    end
    // Unmapped place reads zero
    bus_rd(8'h74, rd);
    chk("unmapped", 32'h0, rd);
    final_report();
  end
endmodule : counter_window_and_dio_regs_tb
`default_nettype wire
